/* File: logic/mmsr_pkg.sv */
// Constants and carrier types for the monitor selector and scratch registers.
// Assumes a serial command decoder upstream that presents whole 16-bit frames.
package mmsr_pkg;

  // ----------------------------------------------------------------
  // Register addresses (5-bit command address field)
  // ----------------------------------------------------------------
  localparam logic [4:0] MMSR_ADDR_MON_SEL    = 5'h00;
  localparam logic [4:0] MMSR_ADDR_SCRATCH_A  = 5'h01;
  localparam logic [4:0] MMSR_ADDR_SCRATCH_D  = 5'h04;
  localparam logic [4:0] MMSR_ADDR_SETUP_LO   = 5'h05;
  localparam logic [4:0] MMSR_ADDR_SETUP_HI   = 5'h08;
  localparam int         MMSR_SCRATCH_COUNT   = 4;

  // ----------------------------------------------------------------
  // Monitor selector field layout and reset values
  // ----------------------------------------------------------------
  localparam int         MMSR_SEL_HI_POS      = 7;
  localparam int         MMSR_SEL_LO_POS      = 5;
  localparam int         MMSR_SENSE_RES_POS   = 4;
  localparam int         MMSR_IO_ATT_POS      = 3;
  localparam logic [7:0] MMSR_MON_SEL_MASK    = 8'hF8;
  localparam logic [7:0] MMSR_MON_SEL_RESET   = 8'h00;
  localparam logic [7:0] MMSR_SCRATCH_RESET   = 8'h00;

  // Source select encodings
  localparam logic [2:0] MMSR_SRC_OFF         = 3'h0;
  localparam logic [2:0] MMSR_SRC_REG_CURRENT = 3'h1;
  localparam logic [2:0] MMSR_SRC_VREF        = 3'h2;
  localparam logic [2:0] MMSR_SRC_TEMP        = 3'h3;
  localparam logic [2:0] MMSR_SRC_WAKE_IO0    = 3'h4;
  localparam logic [2:0] MMSR_SRC_WAKE_IO1    = 3'h5;
  localparam logic [2:0] MMSR_SRC_BATT_SUPPLY = 3'h6;
  localparam logic [2:0] MMSR_SRC_BATT_SENSE  = 3'h7;

  typedef enum logic [1:0] {
    MMSR_MODE_INIT,
    MMSR_MODE_NORMAL,
    MMSR_MODE_OTHER
  } mmsr_mode_t;

  // Decoded command from the serial port, one-cycle valid
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] addr;
    logic [7:0] data;
  } mmsr_cmd_t;

  // Answer to a command
  typedef struct packed {
    logic       valid;
    logic       reject;
    logic [7:0] data;
  } mmsr_rsp_t;

  // Analog monitor controls
  typedef struct packed {
    logic [7:0] route;
    logic       drive_en;
    logic       sense_res_en;
    logic       io_att;
  } mmsr_mon_t;

  typedef struct packed {
    logic [7:0] mon_sel;
    logic [7:0] scratch_a;
    logic [7:0] scratch_b;
    logic [7:0] scratch_c;
    logic [7:0] scratch_d;
    mmsr_rsp_t  rsp;
    mmsr_mon_t  mon;
    logic       setup_wr;
    logic [4:0] setup_addr;
    logic [7:0] setup_data;
  } mmsr_state_t;

endpackage : mmsr_pkg

/* File: logic/mmsr_regs.sv */
// Monitor selector and four scratch bytes behind the decoded serial command port.
// Assumes i_cmd is one-cycle, already parity-checked, and that mode and
// regulator status come from logic on the same clock.
//
// How it works
// - Select 000 disables sources, no drive
// - Select 001 routes regulator current copy
// - Select 010 routes internal voltage reference
// - Select 011 routes temperature sensor voltage
// - Selector access only with regulator on
// - Access while off discarded, selector cleared
// - Selector zero at reset, off, non-normal
// - Four scratch bytes, addresses 1-4, cleared
// - Setup writes accepted only in init
`timescale 1ns/100ps
module mmsr_regs
  import mmsr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire mmsr_cmd_t  i_cmd,
  input  wire logic       i_xcvr_reg_on,
  input  wire mmsr_mode_t i_mode,
  output mmsr_rsp_t       o_rsp,
  output mmsr_mon_t       o_mon,
  output logic            o_setup_wr,
  output logic [4:0]      o_setup_addr,
  output logic [7:0]      o_setup_data
);

  mmsr_state_t state_reg;
  mmsr_state_t state_next;

  logic [2:0] sel_field;
  logic       hit_mon;
  logic       hit_scratch;
  logic       hit_setup;
  logic       sel_hold;

  // ----------------------------------------------------------------
  // Command decode and register update
  // ----------------------------------------------------------------
  always_comb begin
    hit_mon     = i_cmd.addr == MMSR_ADDR_MON_SEL;
    hit_scratch = i_cmd.addr >= MMSR_ADDR_SCRATCH_A && i_cmd.addr <= MMSR_ADDR_SCRATCH_D;
    hit_setup   = i_cmd.addr >= MMSR_ADDR_SETUP_LO && i_cmd.addr <= MMSR_ADDR_SETUP_HI;
    // Selector may only hold a value while the regulator is on in normal mode
    sel_hold    = i_xcvr_reg_on && i_mode == MMSR_MODE_NORMAL;
    state_next  = state_reg;
    state_next.rsp      = '0;
    state_next.setup_wr = 1'b0;

    if (i_cmd.valid) begin
      state_next.rsp.valid = 1'b1;
      if (hit_mon) begin
        if (!i_xcvr_reg_on) begin
          state_next.rsp.reject = 1'b1;
        end else if (i_cmd.write) begin
          // Outside normal mode the write is answered but not stored, and the clear below applies
          if (sel_hold) begin
            state_next.mon_sel = i_cmd.data & MMSR_MON_SEL_MASK;
          end
        end else if (sel_hold) begin
          state_next.rsp.data = state_reg.mon_sel;
        end
      end else if (hit_scratch) begin
        if (i_cmd.write) begin
          case (i_cmd.addr[2:0])
            3'h1:    state_next.scratch_a = i_cmd.data;
            3'h2:    state_next.scratch_b = i_cmd.data;
            3'h3:    state_next.scratch_c = i_cmd.data;
            3'h4:    state_next.scratch_d = i_cmd.data;
            default: state_next.scratch_a = state_reg.scratch_a;
          endcase
        end else begin
          case (i_cmd.addr[2:0])
            3'h1:    state_next.rsp.data = state_reg.scratch_a;
            3'h2:    state_next.rsp.data = state_reg.scratch_b;
            3'h3:    state_next.rsp.data = state_reg.scratch_c;
            3'h4:    state_next.rsp.data = state_reg.scratch_d;
            default: state_next.rsp.data = 8'h00;
          endcase
        end
      end else if (hit_setup && i_cmd.write) begin
        if (i_mode == MMSR_MODE_INIT) begin
          state_next.setup_wr   = 1'b1;
          state_next.setup_addr = i_cmd.addr;
          state_next.setup_data = i_cmd.data;
        end else begin
          state_next.rsp.reject = 1'b1;
        end
      end else begin
        state_next.rsp.reject = 1'b1;
      end
    end

    // Clear overrides any write in the same cycle
    if (!sel_hold) begin
      state_next.mon_sel = MMSR_MON_SEL_RESET;
    end

    // Monitor controls change on the same edge as the stored selector
    sel_field                   = state_next.mon_sel[MMSR_SEL_HI_POS:MMSR_SEL_LO_POS];
    state_next.mon.route        = 8'h00;
    state_next.mon.route[sel_field] = sel_field != MMSR_SRC_OFF;
    state_next.mon.drive_en     = sel_field != MMSR_SRC_OFF;
    state_next.mon.sense_res_en = state_next.mon_sel[MMSR_SENSE_RES_POS];
    // Attenuation only meaningful on the wake pin sources
    state_next.mon.io_att = state_next.mon_sel[MMSR_IO_ATT_POS]
                            && (sel_field == MMSR_SRC_WAKE_IO0
                                || sel_field == MMSR_SRC_WAKE_IO1);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rsp        = state_reg.rsp;
  assign o_mon        = state_reg.mon;
  assign o_setup_wr   = state_reg.setup_wr;
  assign o_setup_addr = state_reg.setup_addr;
  assign o_setup_data = state_reg.setup_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  off_no_drive_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state_reg.mon_sel[7:5] == MMSR_SRC_OFF |-> !o_mon.drive_en && o_mon.route == 8'h00)
    else $error("monitor driven with source off");

  route_onehot_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state_reg.mon_sel[7:5] == MMSR_SRC_REG_CURRENT |-> o_mon.route == 8'h02)
    else $error("regulator current copy not routed");

  vref_route_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state_reg.mon_sel[7:5] == MMSR_SRC_VREF |-> o_mon.route == 8'h04 && o_mon.drive_en)
    else $error("reference not routed");

  temp_route_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state_reg.mon_sel[7:5] == MMSR_SRC_TEMP |-> o_mon.route == 8'h08)
    else $error("temperature sensor not routed");

  att_gate_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_mon.io_att |-> state_reg.mon_sel[7:6] == 2'b10 && state_reg.mon_sel[3])
    else $error("attenuation outside wake pin sources");

  sense_res_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.write && hit_mon && sel_hold
    |=> o_mon.sense_res_en == $past(i_cmd.data[MMSR_SENSE_RES_POS]))
    else $error("sense resistor enable mismatch");

  off_access_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.addr == MMSR_ADDR_MON_SEL && !i_xcvr_reg_on
    |=> o_rsp.reject && state_reg.mon_sel == 8'h00)
    else $error("selector access while off not discarded");

  sel_write_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.write && i_cmd.addr == MMSR_ADDR_MON_SEL && i_xcvr_reg_on
    && i_mode == MMSR_MODE_NORMAL
    |=> state_reg.mon_sel == ($past(i_cmd.data) & 8'hF8))
    else $error("selector write lost");

  sel_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_xcvr_reg_on || i_mode != MMSR_MODE_NORMAL |=> state_reg.mon_sel == 8'h00)
    else $error("selector not cleared");

  scratch_rt_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.write && i_cmd.addr == MMSR_ADDR_SCRATCH_A
    ##1 i_cmd.valid && !i_cmd.write && i_cmd.addr == MMSR_ADDR_SCRATCH_A
    |=> o_rsp.data == $past(i_cmd.data, 2))
    else $error("scratch byte readback wrong");

  setup_gate_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_setup_wr |-> $past(i_mode) == MMSR_MODE_INIT)
    else $error("setup write outside init");

  sel_read_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && !i_cmd.write && hit_mon && sel_hold
    |=> o_rsp.data == $past(state_reg.mon_sel) && !o_rsp.reject)
    else $error("selector read wrong");

  sel_closed_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && hit_mon && !sel_hold |=> o_rsp.data == 8'h00)
    else $error("selector answered while closed");

  setup_reject_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.write && hit_setup && i_mode != MMSR_MODE_INIT
    |=> o_rsp.reject && !o_setup_wr)
    else $error("setup write taken outside init");

  setup_pass_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid && i_cmd.write && hit_setup && i_mode == MMSR_MODE_INIT
    |=> o_setup_wr && o_setup_addr == $past(i_cmd.addr)
        && o_setup_data == $past(i_cmd.data))
    else $error("setup write not forwarded");

  // No disable here: the reset itself is what is checked
  scratch_reset_a: assert property (
    @(posedge i_sys_clk)
    i_rst |=> state_reg.scratch_a == MMSR_SCRATCH_RESET
              && state_reg.scratch_b == MMSR_SCRATCH_RESET
              && state_reg.scratch_c == MMSR_SCRATCH_RESET
              && state_reg.scratch_d == MMSR_SCRATCH_RESET)
    else $error("scratch bytes not cleared by reset");

  rsp_pulse_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.valid |=> o_rsp.valid)
    else $error("command left unanswered");

  rsp_quiet_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_cmd.valid |=> !o_rsp.valid && !o_setup_wr)
    else $error("answer without command");

endmodule : mmsr_regs

/* File: bench/mmsr_host.sv */
// Host-side model of the serial command port, one decoded frame per call.
// Assumes the caller sits just after a rising edge of i_sys_clk.
`timescale 1ns/100ps
module mmsr_host
  import mmsr_pkg::*;
(
  input  wire logic i_sys_clk,
  output mmsr_cmd_t o_cmd
);
  initial o_cmd = '0;

  // Frame changes only on the edge, holds until the next call
  task automatic issue(input logic v, input logic w, input logic [4:0] a,
                       input logic [7:0] d);
    o_cmd <= '{valid: v, write: w, addr: a, data: d};
  endtask : issue
endmodule : mmsr_host

/* File: bench/monitor_mux_and_scratch_regs_test.sv */
// Self-checking bench: random commands, regulator and mode, checked
// against a behavioural model. Assumes the mmsr_regs port contract.
`timescale 1ns/100ps
module monitor_mux_and_scratch_regs_test;
  import mmsr_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_rst     = 1'b1;
  logic       reg_on    = 1'b0;
  mmsr_mode_t mode      = MMSR_MODE_INIT;
  mmsr_cmd_t  cmd;
  mmsr_rsp_t  o_rsp;
  mmsr_mon_t  o_mon;
  logic       o_setup_wr;
  logic [4:0] o_setup_addr;
  logic [7:0] o_setup_data;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         seed        = 59;
  logic [7:0] scr [4];
  logic [7:0] sel, e_d, e_sd;
  logic       e_v, e_rej, e_sw, run = 1'b0;
  logic [4:0] e_sa;

  always #4 i_sys_clk = ~i_sys_clk;

  mmsr_host u_host (.i_sys_clk(i_sys_clk), .o_cmd(cmd));
  mmsr_regs DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cmd(cmd), .i_xcvr_reg_on(reg_on),
    .i_mode(mode), .o_rsp(o_rsp), .o_mon(o_mon), .o_setup_wr(o_setup_wr),
    .o_setup_addr(o_setup_addr), .o_setup_data(o_setup_data));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Reference model, sampled on the same edge as the design
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    run <= 1'b1;
    e_v = 1'b0; e_rej = 1'b0; e_d = 8'h00; e_sw = 1'b0;
    if (i_rst) begin
      sel = 8'h00;
      scr = '{default: 8'h00};
    end else begin
      e_v = cmd.valid;
      e_sa = cmd.addr;
      e_sd = cmd.data;
      if (cmd.valid) begin
        if (cmd.addr == 5'h00) e_rej = !reg_on;
        else if (cmd.addr > 5'h08) e_rej = 1'b1;
        else if (cmd.addr > 5'h04) begin
          e_rej = (mode != MMSR_MODE_INIT);
          e_sw = !e_rej;
        end else if (cmd.write) scr[cmd.addr - 5'h01] = cmd.data;
        else e_d = scr[cmd.addr - 5'h01];
      end
      // Clear wins over a write in the same cycle
      if (!reg_on || mode != MMSR_MODE_NORMAL) sel = 8'h00;
      else if (cmd.valid && cmd.addr == 5'h00) begin
        if (cmd.write) sel = cmd.data & 8'hF8;
        else e_d = sel;
      end
    end
  end

  always @(negedge i_sys_clk) if (run) begin
    chk("rsp_valid", o_rsp.valid, e_v);
    chk("rsp_reject", o_rsp.reject, e_rej);
    chk("rsp_data", o_rsp.data, e_d);
    chk("route", o_mon.route, sel[7:5] == 3'h0 ? 8'h00 : 8'h01 << sel[7:5]);
    chk("drive_en", o_mon.drive_en, sel[7:5] != 3'h0);
    chk("sense_res", o_mon.sense_res_en, sel[4]);
    chk("io_att", o_mon.io_att, sel[3] & (sel[7:6] == 2'b10));
    chk("setup_wr", o_setup_wr, e_sw);
    if (e_sw) chk("setup_addr", o_setup_addr, e_sa);
    if (e_sw) chk("setup_data", o_setup_data, e_sd);
  end

  // ----------------------------------------------------------------
  // Random stimulus, with a second reset in mid-run
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [4:0]  a;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge i_sys_clk);
      r = $random(seed);
      a = (r[13] && r[14]) ? r[12:8] : 5'(r[11:8] % 9);
      i_rst <= (i >= 1500 && i < 1503);
      reg_on <= (r[3:0] != 4'h0);
      mode <= r[6:4] == 3'h0 ? MMSR_MODE_INIT :
              (r[6:4] == 3'h1 ? MMSR_MODE_OTHER : MMSR_MODE_NORMAL);
      // Setup reads have no defined answer, so they go out as writes
      u_host.issue(r[15] | r[16], r[7] | (a > 5'h04 && a < 5'h09), a, r[31:24]);
    end
    repeat (2) @(posedge i_sys_clk);
    stop_test();
  end

  initial begin
    #60000;
    miscompares++;
    stop_test();
  end
endmodule : monitor_mux_and_scratch_regs_test
